// ==== hw/eep_params.svh ====
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH
// core clock period
`define EEP_CLK_NS 5
// self-timed programming limit, longest time so it rounds down
`define EEP_WR_TIME_US 5000
`define EEP_WR_CYCLES (`EEP_WR_TIME_US * 1000 / `EEP_CLK_NS)
// bus clock period made by the master end, split into four quarters
`define EEP_SCL_NS 1000
`define EEP_QTR_CYCLES (`EEP_SCL_NS / 4 / `EEP_CLK_NS)
// device-type code in the top nibble of the address byte; arbitrary value
`define EEP_TYPE_CODE 4'h6
// content of an erased cell
`define EEP_MEM_INIT 8'hFF
// array size in bytes and page size in bytes
`define EEP_MEM_DEPTH 256
`define EEP_PAGE_BYTES 16
// bit count at which the acknowledge slot follows
`define EEP_BYTE_BITS 4'h8
// clock pulses allowed for bus recovery
`define EEP_RECOV_PULSES 4'h9
`endif

// ==== hw/eep_pkg.sv ====
package eep_pkg;
	// device sequencer states, gray along the usual path
	typedef enum logic [3:0] {
		DS_IDLE     = 4'h0,
		DS_ADDR     = 4'h1,
		DS_ADDR_ACK = 4'h3,
		DS_WORD     = 4'h2,
		DS_WORD_ACK = 4'h6,
		DS_DATA     = 4'h7,
		DS_DATA_ACK = 4'h5,
		DS_SEND     = 4'h4,
		DS_SEND_ACK = 4'hC
	} eep_dev_state_e;
	// master end states
	typedef enum logic {
		HS_IDLE = 1'h0,
		HS_RUN  = 1'h1
	} eep_host_state_e;
	// byte-level bus operations offered by the master end
	typedef enum logic [2:0] {
		OP_START   = 3'h0,
		OP_STOP    = 3'h1,
		OP_WRITE   = 3'h2,
		OP_READ    = 3'h3,
		OP_RECOVER = 3'h4
	} eep_op_e;
endpackage : eep_pkg

// ==== hw/eep_link_if.sv ====
interface eep_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// wired-and with pull-up: any enabled driver showing low wins
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);
	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);
endinterface : eep_link_if

// ==== hw/eep_dev.sv ====
`include "eep_params.svh"
module eep_dev #(
	parameter int WR_CYCLES = `EEP_WR_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	eep_link_if.dev   link,
	input  wire logic addr_select_bit0,
	input  wire logic addr_select_bit1,
	input  wire logic addr_select_bit2,
	input  wire logic write_protect,
	output logic      standby
);
	import eep_pkg::*;
	localparam int WCW = $clog2(WR_CYCLES + 1);

	// pin synchronisers {sel2,sel1,sel0,wp,sda,scl}; bus lines idle high
	logic [5:0] sy1_q;
	logic [5:0] sy2_q;
	logic       scl_p_q;
	logic       sda_p_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sy1_q   <= 6'h03;
			sy2_q   <= 6'h03;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			sy1_q   <= {addr_select_bit2, addr_select_bit1, addr_select_bit0,
				write_protect, link.sda, link.scl};
			sy2_q   <= sy1_q;
			scl_p_q <= sy2_q[0];
			sda_p_q <= sy2_q[1];
		end
	end

	logic       scl;
	logic       sda;
	logic       wp;
	logic [2:0] sel;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	assign scl  = sy2_q[0];
	assign sda  = sy2_q[1];
	assign wp   = sy2_q[2];
	assign sel  = sy2_q[5:3];
	// data is taken on clock rise and changed after clock fall
	// edge-qualified sampling
	assign rise = scl & ~scl_p_q;
	assign fall = ~scl & scl_p_q;
	assign start = scl & scl_p_q & sda_p_q & ~sda;
	assign stop  = scl & scl_p_q & ~sda_p_q & sda;

	eep_dev_state_e st_q, st_d;
	logic [3:0]     cnt_q, cnt_d;
	logic [7:0]     sh_q, sh_d;
	logic [7:0]     ptr_q, ptr_d;
	logic           rw_q, rw_d;
	logic           more_q, more_d;
	logic           drv_q, drv_d;
	logic           busy_q, busy_d;
	logic [WCW-1:0] wcnt_q, wcnt_d;
	logic [3:0]     page_q, page_d;
	logic [15:0]    vld_q, vld_d;
	logic [7:0]     buf_q [`EEP_PAGE_BYTES];
	logic [7:0]     buf_d [`EEP_PAGE_BYTES];
	logic [7:0]     mem_q [`EEP_MEM_DEPTH];
	logic [7:0]     mem_d [`EEP_MEM_DEPTH];
	logic           commit;

	// sequencer next-state; start overrides everything so a lost master can recover
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		ptr_d  = ptr_q;
		rw_d   = rw_q;
		more_d = more_q;
		drv_d  = drv_q;
		page_d = page_q;
		vld_d  = vld_q;
		buf_d  = buf_q;
		commit = 1'b0;
		if (start)
		begin
			// start returns the sequencer to address phase
			st_d  = DS_ADDR;
			cnt_d = 4'h0;
			drv_d = 1'b0;
			vld_d = 16'h0000;
		end
		else if (stop)
		begin
			// stop after a read lands in standby
			st_d  = DS_IDLE;
			drv_d = 1'b0;
			// stop launches programming of buffered bytes
			if ((st_q == DS_DATA || st_q == DS_DATA_ACK) && (|vld_q) && !wp)
				commit = 1'b1;
		end
		else
		begin
			case (st_q)
				DS_ADDR, DS_WORD, DS_DATA:
				begin
					if (rise)
					begin
						sh_d  = {sh_q[6:0], sda};
						cnt_d = cnt_q + 4'h1;
					end
					else if (fall && cnt_q == `EEP_BYTE_BITS)
					begin
						cnt_d = 4'h0;
						drv_d = 1'b1;
						if (st_q == DS_ADDR)
						begin
							// type code and select pins must match
							if (sh_q[7:4] == `EEP_TYPE_CODE && sh_q[3:1] == sel && !busy_q)
							begin
								st_d = DS_ADDR_ACK;
								rw_d = sh_q[0];
							end
							else
							begin
								st_d  = DS_IDLE;
								drv_d = 1'b0;
							end
						end
						else if (st_q == DS_WORD)
						begin
							// word address also seeds a later read
							ptr_d = sh_q;
							st_d  = DS_WORD_ACK;
						end
						else
						begin
							// later bytes replace earlier ones in the same slot
							buf_d[ptr_q[3:0]] = sh_q;
							vld_d[ptr_q[3:0]] = 1'b1;
							page_d            = ptr_q[7:4];
							ptr_d             = {ptr_q[7:4], ptr_q[3:0] + 4'h1};
							st_d              = DS_DATA_ACK;
						end
					end
				end
				DS_ADDR_ACK:
				begin
					// acknowledge held for the whole ninth clock
					if (fall)
					begin
						if (rw_q)
						begin
							// read begins at the address counter
							sh_d  = mem_q[ptr_q];
							drv_d = ~mem_q[ptr_q][7];
							st_d  = DS_SEND;
						end
						else
						begin
							drv_d = 1'b0;
							st_d  = DS_WORD;
						end
					end
				end
				DS_WORD_ACK, DS_DATA_ACK:
				begin
					// every data byte acknowledged at once
					if (fall)
					begin
						drv_d = 1'b0;
						st_d  = DS_DATA;
					end
				end
				DS_SEND:
				begin
					if (rise)
						cnt_d = cnt_q + 4'h1;
					else if (fall)
					begin
						if (cnt_q == `EEP_BYTE_BITS)
						begin
							cnt_d = 4'h0;
							drv_d = 1'b0;
							// full counter increment, wraps to zero
							ptr_d = ptr_q + 8'h01;
							st_d  = DS_SEND_ACK;
						end
						else
						begin
							sh_d  = {sh_q[6:0], 1'b0};
							drv_d = ~sh_q[6];
						end
					end
				end
				DS_SEND_ACK:
				begin
					if (rise)
						more_d = ~sda;
					else if (fall)
					begin
						// acknowledged byte is followed by the next
						if (more_q)
						begin
							sh_d  = mem_q[ptr_q];
							drv_d = ~mem_q[ptr_q][7];
							st_d  = DS_SEND;
						end
						else
							st_d = DS_IDLE;
					end
				end
				default:
					st_d = DS_IDLE;
			endcase
		end
	end

	// programming timer; every buffered byte of the page lands in one cycle so there is no partial write
	always_comb
	begin
		busy_d = busy_q;
		wcnt_d = wcnt_q;
		mem_d  = mem_q;
		for (int i = 0; i < `EEP_PAGE_BYTES; i++)
		begin
			if (commit && vld_q[i])
				mem_d[{page_q, 4'(i)}] = buf_q[i];
		end
		if (commit)
		begin
			busy_d = 1'b1;
			wcnt_d = '0;
		end
		// busy ends after the bounded write time
		else if (busy_q)
		begin
			if (wcnt_q == WCW'(WR_CYCLES - 1))
				busy_d = 1'b0;
			else
				wcnt_d = wcnt_q + WCW'(1);
		end
	end

	// state registers; array starts erased
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q   <= DS_IDLE;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			ptr_q  <= 8'h00;
			rw_q   <= 1'b0;
			more_q <= 1'b0;
			drv_q  <= 1'b0;
			busy_q <= 1'b0;
			wcnt_q <= '0;
			page_q <= 4'h0;
			vld_q  <= 16'h0000;
			buf_q  <= '{default: 8'h00};
			mem_q  <= '{default: `EEP_MEM_INIT};
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			ptr_q  <= ptr_d;
			rw_q   <= rw_d;
			more_q <= more_d;
			drv_q  <= drv_d;
			busy_q <= busy_d;
			wcnt_q <= wcnt_d;
			page_q <= page_d;
			vld_q  <= vld_d;
			buf_q  <= buf_d;
			mem_q  <= mem_d;
		end
	end

	// open-drain output: only ever pulls low
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = drv_q;
	// standby whenever idle and not programming
	assign standby = (st_q == DS_IDLE) && !busy_q;
endmodule : eep_dev

// ==== hw/eep_host.sv ====
`include "eep_params.svh"
module eep_host #(
	parameter int QTR_CYCLES = `EEP_QTR_CYCLES
) (
	input  wire logic         clk,
	input  wire logic         rst,
	eep_link_if.host          link,
	input  wire logic         op_valid,
	output logic              op_ready,
	input  eep_pkg::eep_op_e  op_code,
	input  wire logic [7:0]   op_wdata,
	input  wire logic         op_ack_out,
	output logic              res_valid,
	output logic [7:0]        res_rdata,
	output logic              res_ack
);
	import eep_pkg::*;
	localparam int TW = $clog2(QTR_CYCLES + 1);

	// data line comes back from the far end, so synchronise it
	logic sda1_q;
	logic sda2_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sda1_q <= 1'b1;
			sda2_q <= 1'b1;
		end
		else
		begin
			sda1_q <= link.sda;
			sda2_q <= sda1_q;
		end
	end

	eep_host_state_e hs_q, hs_d;
	eep_op_e         op_q, op_d;
	logic [1:0]      ph_q, ph_d;
	logic [3:0]      bit_q, bit_d;
	logic [TW-1:0]   tq_q, tq_d;
	logic [7:0]      wd_q, wd_d;
	logic            ao_q, ao_d;
	logic            sclh_q, sclh_d;
	logic            sdar_q, sdar_d;
	logic [7:0]      rx_q, rx_d;
	logic            ack_q, ack_d;
	logic            rv_q, rv_d;
	logic            tick;
	logic            bitval;

	assign tick = (tq_q == TW'(QTR_CYCLES - 1));
	// bit to present: data bits, then ack slot released (write) or master ack (read)
	always_comb
	begin
		if (bit_q < `EEP_BYTE_BITS)
			bitval = (op_q == OP_WRITE) ? wd_q[3'h7 - bit_q[2:0]] : 1'b1;
		else
			bitval = (op_q == OP_WRITE) ? 1'b1 : ~ao_q;
	end

	// quarter-period sequencer; data only moves while the clock is low, except in start and stop
	always_comb
	begin
		hs_d   = hs_q;
		op_d   = op_q;
		ph_d   = ph_q;
		bit_d  = bit_q;
		tq_d   = tq_q;
		wd_d   = wd_q;
		ao_d   = ao_q;
		sclh_d = sclh_q;
		sdar_d = sdar_q;
		rx_d   = rx_q;
		ack_d  = ack_q;
		rv_d   = 1'b0;
		case (hs_q)
			HS_IDLE:
			begin
				if (op_valid)
				begin
					hs_d  = HS_RUN;
					op_d  = op_code;
					wd_d  = op_wdata;
					ao_d  = op_ack_out;
					ph_d  = 2'h0;
					bit_d = 4'h0;
					tq_d  = '0;
				end
			end
			HS_RUN:
			begin
				tq_d = tick ? '0 : tq_q + TW'(1);
				if (tick)
				begin
					ph_d = ph_q + 2'h1;
					case (op_q)
						OP_START:
						begin
							// data falls while the clock is high
							case (ph_q)
								2'h0: sdar_d = 1'b1;
								2'h1: sclh_d = 1'b1;
								2'h2: sdar_d = 1'b0;
								default:
								begin
									sclh_d = 1'b0;
									hs_d   = HS_IDLE;
									rv_d   = 1'b1;
								end
							endcase
						end
						OP_STOP:
						begin
							// data rises while the clock is high
							case (ph_q)
								2'h0: sclh_d = 1'b0;
								2'h1: sdar_d = 1'b0;
								2'h2: sclh_d = 1'b1;
								default:
								begin
									sdar_d = 1'b1;
									hs_d   = HS_IDLE;
									rv_d   = 1'b1;
								end
							endcase
						end
						OP_RECOVER:
						begin
							// pulse until data reads high or the ninth pulse is reached, then start
							case (ph_q)
								2'h0:
								begin
									sclh_d = 1'b0;
									sdar_d = 1'b1;
								end
								2'h1: sclh_d = 1'b1;
								2'h2:
								begin
									if (sda2_q || bit_q == `EEP_RECOV_PULSES - 4'h1)
									begin
										// run the whole start from its first quarter, clock still high
										op_d = OP_START;
										ph_d = 2'h0;
									end
								end
								default:
								begin
									sclh_d = 1'b0;
									bit_d  = bit_q + 4'h1;
								end
							endcase
						end
						default:
						begin
							// one clock pulse per bit, data set while low
							case (ph_q)
								2'h0:
								begin
									sclh_d = 1'b0;
									sdar_d = bitval;
								end
								2'h1: sclh_d = 1'b1;
								2'h2:
								begin
									if (bit_q < `EEP_BYTE_BITS)
										rx_d = {rx_q[6:0], sda2_q};
									else if (op_q == OP_WRITE)
										ack_d = ~sda2_q;
								end
								default:
								begin
									sclh_d = 1'b0;
									bit_d  = bit_q + 4'h1;
									if (bit_q == `EEP_BYTE_BITS)
									begin
										hs_d = HS_IDLE;
										rv_d = 1'b1;
									end
								end
							endcase
						end
					endcase
				end
			end
			default:
				hs_d = HS_IDLE;
		endcase
	end

	// registers; both lines released after reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hs_q   <= HS_IDLE;
			op_q   <= OP_START;
			ph_q   <= 2'h0;
			bit_q  <= 4'h0;
			tq_q   <= '0;
			wd_q   <= 8'h00;
			ao_q   <= 1'b0;
			sclh_q <= 1'b1;
			sdar_q <= 1'b1;
			rx_q   <= 8'h00;
			ack_q  <= 1'b0;
			rv_q   <= 1'b0;
		end
		else
		begin
			hs_q   <= hs_d;
			op_q   <= op_d;
			ph_q   <= ph_d;
			bit_q  <= bit_d;
			tq_q   <= tq_d;
			wd_q   <= wd_d;
			ao_q   <= ao_d;
			sclh_q <= sclh_d;
			sdar_q <= sdar_d;
			rx_q   <= rx_d;
			ack_q  <= ack_d;
			rv_q   <= rv_d;
		end
	end

	// open-drain style: enable only when pulling low
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = ~sclh_q;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = ~sdar_q;
	assign op_ready  = (hs_q == HS_IDLE);
	assign res_valid = rv_q;
	assign res_rdata = rx_q;
	assign res_ack   = ack_q;
endmodule : eep_host

// ==== test/eep_link_properties.sv ====
`include "eep_params.svh"
module eep_link_properties #(
	parameter int WR_CYCLES = `EEP_WR_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic write_protect
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int IDLE_T = WR_CYCLES + 25;
	// decoded view of the resolved bus lines
	typedef struct packed {
		logic        scl;
		logic        sda;
		logic        seen;
		logic        first;
		logic        rd;
		logic        mute;
		logic        wrote;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [1:0]  nb;
		logic [31:0] since;
	} eep_mon_s;
	eep_mon_s mon_q;
	eep_mon_s mon_d;
	logic     rise;
	logic     start_ev;
	logic     stop_ev;
	logic     ack_slot;
	// conditions seen on the wires
	assign rise     = scl & ~mon_q.scl;
	assign start_ev = scl & mon_q.scl & mon_q.sda & ~sda;
	assign stop_ev  = scl & mon_q.scl & ~mon_q.sda & sda;
	assign ack_slot = rise & (mon_q.cnt == 4'h8);
	// write timer saturates, so it never wraps into a false busy window
	always_comb
	begin
		mon_d = mon_q;
		mon_d.scl = scl;
		mon_d.sda = sda;
		mon_d.seen = mon_q.seen | start_ev;
		if (mon_q.since < IDLE_T)
			mon_d.since = mon_q.since + 32'h0000_0001;
		if (rise)
		begin
			mon_d.sh = {mon_q.sh[6:0], sda};
			mon_d.cnt = (mon_q.cnt == 4'h8) ? 4'h0 : mon_q.cnt + 4'h1;
		end
		if (ack_slot)
		begin
			mon_d.first = 1'b0;
			mon_d.nb = (mon_q.nb == 2'h3) ? mon_q.nb : mon_q.nb + 2'h1;
			if (mon_q.first)
			begin
				mon_d.rd = mon_q.sh[0] & ~sda;
				mon_d.mute = mon_q.sh[7:4] != `EEP_TYPE_CODE;
			end
			if (mon_q.nb >= 2'h2 && !mon_q.rd && !sda)
				mon_d.wrote = 1'b1;
		end
		if (start_ev)
		begin
			mon_d.first = 1'b1;
			mon_d.cnt = 4'h0;
			mon_d.nb = 2'h0;
			mon_d.rd = 1'b0;
			mon_d.mute = 1'b0;
			mon_d.wrote = 1'b0;
		end
		if (stop_ev)
		begin
			mon_d.rd = 1'b0;
			mon_d.wrote = 1'b0;
			if (mon_q.wrote && !write_protect)
				mon_d.since = 32'h0000_0000;
		end
	end
	// lines released and no write being timed after reset
	always_ff @(posedge clk)
	begin
		if (rst)
			mon_q <= '{scl: 1'b1, sda: 1'b1, since: 32'(IDLE_T), default: '0};
		else
			mon_q <= mon_d;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_dev_edge_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	property p_sda_settled;
		$rose(scl) |=> $stable(sda) [*6];
	endproperty
	property p_quiet_before_start;
		!mon_q.seen |-> !dev_sda_oe;
	endproperty
	property p_mismatch_quiet;
		(mon_q.mute || (mon_q.first && mon_q.cnt == 4'h8 && mon_q.sh[7:4] != `EEP_TYPE_CODE))
			|-> !dev_sda_oe;
	endproperty
	property p_ack_ninth;
		rise && !mon_q.rd && dev_sda_oe |-> mon_q.cnt == 4'h8;
	endproperty
	property p_master_slot_free;
		ack_slot && mon_q.rd |-> !dev_sda_oe;
	endproperty
	property p_busy_no_ack;
		ack_slot && mon_q.first && mon_q.since < WR_CYCLES |-> !dev_sda_oe;
	endproperty
	property p_busy_bounded;
		ack_slot && mon_q.first && mon_q.since >= IDLE_T
			&& mon_q.sh[7:4] == `EEP_TYPE_CODE && !mon_q.sh[0] |-> dev_sda_oe;
	endproperty
	// both ends may only pull the lines low, never push them high
	property p_open_drain;
		!dev_sda_o && !host_sda_o && !host_scl_o;
	endproperty
	a_dev_edge_low: assert property (p_dev_edge_low) else $error("sda moved, scl high");
	a_sda_settled: assert property (p_sda_settled) else $error("sda unsettled");
	a_quiet_before_start: assert property (p_quiet_before_start) else $error("early drive");
	a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("foreign ack");
	a_ack_ninth: assert property (p_ack_ninth) else $error("ack off slot");
	a_master_slot_free: assert property (p_master_slot_free) else $error("slot held");
	a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack while busy");
	a_busy_bounded: assert property (p_busy_bounded) else $error("write too long");
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	c_poll_refused: cover property (ack_slot && mon_q.first && sda);
	c_read_more: cover property (ack_slot && mon_q.rd && !sda);
	c_mismatch: cover property (mon_q.mute && start_ev);
endmodule : eep_link_properties

// ==== test/tb_top.sv ====
`include "eep_params.svh"
module tb_top import eep_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int         WR  = 400;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] AW  = {`EEP_TYPE_CODE, SEL, 1'b0};
	localparam logic [7:0] AR  = {`EEP_TYPE_CODE, SEL, 1'b1};
	logic       clk, rst, op_valid, op_ready, op_ack_out, res_valid, res_ack;
	logic       write_protect, standby;
	logic [2:0] sel_pins;
	logic [7:0] op_wdata, res_rdata;
	eep_op_e    op_code;
	int         fail_count, comparisons, i;
	eep_link_if u_eep_link_if ();
	eep_dev #(.WR_CYCLES(WR)) u_eep_dev (.clk(clk), .rst(rst), .link(u_eep_link_if),
		.addr_select_bit0(sel_pins[0]), .addr_select_bit1(sel_pins[1]),
		.addr_select_bit2(sel_pins[2]), .write_protect(write_protect), .standby(standby));
	eep_host #(.QTR_CYCLES(8)) u_eep_host (.clk(clk), .rst(rst), .link(u_eep_link_if),
		.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_wdata(op_wdata),
		.op_ack_out(op_ack_out), .res_valid(res_valid), .res_rdata(res_rdata),
		.res_ack(res_ack));
	eep_link_properties #(.WR_CYCLES(WR)) u_eep_link_properties (.clk(clk), .rst(rst),
		.host_scl_o(u_eep_link_if.host_scl_o), .host_scl_oe(u_eep_link_if.host_scl_oe),
		.host_sda_o(u_eep_link_if.host_sda_o), .host_sda_oe(u_eep_link_if.host_sda_oe),
		.dev_sda_o(u_eep_link_if.dev_sda_o), .dev_sda_oe(u_eep_link_if.dev_sda_oe),
		.scl(u_eep_link_if.scl), .sda(u_eep_link_if.sda), .write_protect(write_protect));
	// core clock only; the host divides it down for the bus clock
	always #2.5 clk = ~clk;
	task automatic chk1(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : chk1
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic stop_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// offered at a falling edge and held until a rising edge takes it
	task automatic xfer(input eep_op_e c, input logic [7:0] d, input logic a);
		int n;
		@(negedge clk);
		op_valid = 1'b1;
		op_code = c;
		op_wdata = d;
		op_ack_out = a;
		while (op_ready !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		op_valid = 1'b0;
		n = 0;
		while (res_valid !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk1("res_valid", 1'b1, res_valid);
	endtask : xfer
	task automatic sta();
		xfer(OP_START, 8'h00, 1'b0);
	endtask : sta
	task automatic sto();
		xfer(OP_STOP, 8'h00, 1'b0);
	endtask : sto
	task automatic wr(input logic [7:0] d, input logic e);
		xfer(OP_WRITE, d, 1'b0);
		chk1("ack", e, res_ack);
	endtask : wr
	task automatic rd(input logic a, input logic [7:0] e);
		xfer(OP_READ, 8'h00, a);
		chk8("rdata", e, res_rdata);
	endtask : rd
	// dummy write of the word address, then a repeated start for reading
	task automatic seek(input logic [7:0] w);
		sta();
		wr(AW, 1'b1);
		wr(w, 1'b1);
		sta();
		wr(AR, 1'b1);
	endtask : seek
	task automatic poll(input logic e);
		sta();
		wr(AW, e);
		sto();
	endtask : poll
	// the device sees the stop a few cycles after the host finishes it
	task automatic idle_chk(input logic e);
		repeat (4) @(posedge clk);
		#1;
		chk1("standby", e, standby);
	endtask : idle_chk
	// cuts a hang short well above the expected run of about 22400 cycles
	initial
	begin
		repeat (80000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		op_valid = 1'b0;
		op_code = OP_START;
		op_wdata = 8'h00;
		op_ack_out = 1'b0;
		write_protect = 1'b0;
		sel_pins = SEL;
		fail_count = 0;
		comparisons = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		idle_chk(1'b1);
		sta();
		wr(AR, 1'b1);
		rd(1'b0, 8'hFF);
		sto();
		idle_chk(1'b1);
		sta();
		wr(AW, 1'b1);
		wr(8'h2E, 1'b1);
		for (i = 0; i < 18; i++)
			wr(8'h40 + 8'(i), 1'b1);
		sto();
		idle_chk(1'b0);
		poll(1'b0);
		poll(1'b1);
		idle_chk(1'b1);
		seek(8'h20);
		for (i = 0; i < 16; i++)
			rd(i < 15, (i < 14) ? 8'h42 + 8'(i) : 8'h50 + 8'(i - 14));
		sto();
		sta();
		wr(AW, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h7F, 1'b1);
		wr(8'h80, 1'b1);
		sto();
		poll(1'b0);
		poll(1'b1);
		seek(8'hFF);
		rd(1'b1, 8'hFF);
		rd(1'b0, 8'h7F);
		sto();
		sta();
		wr(AR, 1'b1);
		rd(1'b0, 8'h80);
		sto();
		seek(8'hFF);
		rd(1'b1, 8'hFF);
		xfer(OP_RECOVER, 8'h00, 1'b0);
		wr(AW, 1'b1);
		sto();
		@(negedge clk);
		write_protect = 1'b1;
		sta();
		wr(AW, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h11, 1'b1);
		sto();
		idle_chk(1'b1);
		@(negedge clk);
		write_protect = 1'b0;
		seek(8'h00);
		rd(1'b0, 8'h7F);
		sto();
		sta();
		wr(AW ^ 8'h10, 1'b0);
		wr(8'h00, 1'b0);
		sto();
		sta();
		wr(AR ^ 8'h04, 1'b0);
		sto();
		@(negedge clk);
		sel_pins = 3'h1;
		sta();
		wr({`EEP_TYPE_CODE, 3'h1, 1'b1}, 1'b1);
		rd(1'b0, 8'h80);
		sto();
		stop_test();
	end
endmodule : tb_top
